// file: rtl/apj_top.sv
// command execution for servo polarity, sync wait, slip guard, limits and jog
//
// Operation
// (RULE1) polarity query answers n or i
// (RULE2) invert flips output sign for active axis
// (RULE3) normal restores sign, normal after reset
// (RULE4) sync wait holds commands until input high
// (RULE5) host picks bit 0..7, set as input
// (RULE6) wire-ORed aux lines hold until all release
// (RULE7) slip guard off disables slip kill
// (RULE8) travel window stores upper then lower
// (RULE9) reaching soft limit raises limit condition
// (RULE10) limits compare the absolute position register
// (RULE11) soft and hard limits both trigger
// (RULE12) window of zero, zero disables limits
// (RULE13) window query gives upper then lower
// (RULE14) soft limit sets flag, host notified
// (RULE15) timed jog 0 to 200000 ms
// (RULE16) multi-axis jog starts together, stops separately
// (RULE17) jog time plus accel plus decel
// (RULE18) jog costs six entries plus extras
// (RULE19) slip beyond deadband kills motion when enabled
// (RULE20) slip kill off after reset
// (RULE21) per-axis state, commands hit active axis
`include "apj_consts.svh"
module apj_top import apj_pkg::*; #(
  parameter int TICKS_PER_MS = `APJ_TICKS_PER_MS
) (
  input  wire logic                    i_core_clk,
  input  wire logic                    i_rst,
  input  wire logic [7:0]              i_addr,
  input  wire logic [31:0]             i_wr_data,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic      [31:0]             o_rd_data,
  input  wire logic [7:0]              i_gpio,
  input  wire logic [`APJ_NAX-1:0]     i_limit_sw,
  input  wire logic [`APJ_NAX*32-1:0]  i_axis_pos,
  input  wire logic [`APJ_NAX*16-1:0]  i_servo_cmd,
  input  wire logic [`APJ_NAX-1:0]     i_slip_over,
  input  wire logic [`APJ_NAX-1:0]     i_at_rest,
  output logic      [`APJ_NAX*16-1:0]  o_servo_out,
  output logic      [`APJ_NAX-1:0]     o_kill,
  output logic      [`APJ_NAX-1:0]     o_limit,
  output logic                         o_limit_note,
  output logic      [`APJ_NAX-1:0]     o_jog_run,
  output logic      [`APJ_NAX-1:0]     o_jog_busy,
  output logic                         o_sync_hold
);
  localparam int NAX = `APJ_NAX;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  apj_ctl_t           ctl;
  logic [1:0]         ax;
  logic [31:0]        arg0;
  logic [31:0]        arg1;
  logic               pend_v;
  logic [3:0]         pend_op;
  logic [NAX-1:0]     pend_mask;
  logic [2:0]         sync_bit;
  logic [NAX-1:0]     invert;
  logic [NAX-1:0]     slip_en;
  logic [NAX-1:0]     flag;
  logic [NAX-1:0]     pa_mode;
  logic [NAX-1:0]     enc_axis;
  logic [NAX-1:0]     jog_start;
  logic               ovf;
  logic               range_err;
  logic [7:0]         resp_ch;
  logic [3:0]         qcost;
  logic signed [31:0] upper [NAX];
  logic signed [31:0] lower [NAX];
  logic [31:0]        jtime [NAX];
  logic signed [31:0] q_up;
  logic signed [31:0] q_lo;
  logic [7:0]         gpio_m;
  logic [7:0]         gpio_s;
  logic [NAX-1:0]     lim_m;
  logic [NAX-1:0]     lim_s;
  logic [NAX-1:0]     lim_hit;
  // queue entries taken by each command kind
  function automatic logic [3:0] q_cost(input logic [3:0] op, input logic pa, input logic enc);
    case (op)
      `APJ_OP_JOG:      q_cost = `APJ_Q_JOG + {3'h0, pa} + {3'h0, enc}; // RULE18
      `APJ_OP_SYNC:     q_cost = `APJ_Q_SYNC;
      `APJ_OP_SLIP_OFF: q_cost = `APJ_Q_SLIP;
      `APJ_OP_SLIP_ON:  q_cost = `APJ_Q_SLIP;
      `APJ_OP_TRAVEL:   q_cost = `APJ_Q_TRAVEL;
      default:          q_cost = `APJ_Q_IMM;
    endcase
  endfunction
  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  wire wr_cmd   = i_wr && (i_addr == `APJ_OFF_CMD);
  wire wr_axis  = i_wr && (i_addr == `APJ_OFF_AXIS);
  wire wr_arg0  = i_wr && (i_addr == `APJ_OFF_ARG0);
  wire wr_arg1  = i_wr && (i_addr == `APJ_OFF_ARG1);
  wire wr_clr   = i_wr && (i_addr == `APJ_OFF_FLAGCLR);
  wire wr_cfg   = i_wr && (i_addr == `APJ_OFF_AXCFG);
  wire wr_jt    = i_wr && (i_addr[7:4] == `APJ_OFF_JT_HI);
  wire [1:0] jt_idx = i_addr[3:2];
  // a held sync wait stops the next command
  wire exec      = pend_v && (ctl == apj_run); // RULE4
  wire take_cmd  = wr_cmd && (!pend_v || exec);
  wire [NAX-1:0] ax_hot   = NAX'(1) << ax;
  // empty mask means the active axis only
  wire [NAX-1:0] jog_sel  = (pend_mask == '0) ? ax_hot : pend_mask;
  wire [NAX-1:0] jog_bad;
  wire           is_jog   = exec && (pend_op == `APJ_OP_JOG);
  // line high means every wired aux output has let go
  wire           release_w = gpio_s[sync_bit]; // RULE6
  // read mux and status word
  wire [31:0] status_w = {12'h000, invert, o_jog_busy, slip_en, flag,
                          range_err, ovf, pend_v, ctl == apj_hold};
  wire [31:0] rd_mux =
    (i_addr == `APJ_OFF_AXIS)          ? {30'h0, ax} :
    (i_addr == `APJ_OFF_ARG0)          ? arg0 :
    (i_addr == `APJ_OFF_ARG1)          ? arg1 :
    (i_addr == `APJ_OFF_STATUS)        ? status_w :
    (i_addr == `APJ_OFF_RESP)          ? {20'h0, qcost, resp_ch} :
    (i_addr == `APJ_OFF_QUP)           ? q_up :
    (i_addr == `APJ_OFF_QLO)           ? q_lo :
    (i_addr == `APJ_OFF_AXCFG)         ? {24'h0, enc_axis, pa_mode} :
    (i_addr[7:4] == `APJ_OFF_JT_HI)    ? jtime[jt_idx] : 32'h0;
  // pin synchronisers, two flops per pin
  always_ff @(posedge i_core_clk) begin
    gpio_m <= i_gpio;
    gpio_s <= gpio_m;
    lim_m  <= i_limit_sw;
    lim_s  <= lim_m;
  end
  // read data for one cycle only
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_rd_data <= 32'h0;
    end else begin
      o_rd_data <= i_rd ? rd_mux : 32'h0;
    end
  end
  // software written registers
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ax       <= 2'h0;
      arg0     <= 32'h0;
      arg1     <= 32'h0;
      pa_mode  <= '0;
      enc_axis <= '0;
      for (int i = 0; i < NAX; i++) jtime[i] <= 32'h0;
    end else begin
      if (wr_axis) ax <= i_wr_data[1:0];
      if (wr_arg0) arg0 <= i_wr_data;
      if (wr_arg1) arg1 <= i_wr_data;
      if (wr_cfg) {enc_axis, pa_mode} <= i_wr_data[2*NAX-1:0];
      if (wr_jt) jtime[jt_idx] <= i_wr_data;
    end
  end
  // one pending command, extra writes flagged
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pend_v    <= 1'b0;
      pend_op   <= 4'h0;
      pend_mask <= '0;
    end else if (take_cmd) begin
      pend_v    <= 1'b1;
      pend_op   <= i_wr_data[3:0];
      pend_mask <= i_wr_data[7:4];
    end else if (exec) begin
      pend_v    <= 1'b0;
    end
  end
  // sync wait hold and release
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ctl      <= apj_run;
      sync_bit <= 3'h0;
    end else if (exec && (pend_op == `APJ_OP_SYNC)) begin
      ctl      <= apj_hold; // RULE4
      sync_bit <= arg0[2:0]; // RULE5
    end else if ((ctl == apj_hold) && release_w) begin
      ctl      <= apj_run; // RULE4
    end
  end
  // per-axis settings and query answers
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      invert  <= '0; // RULE3
      slip_en <= '0; // RULE20
      resp_ch <= 8'h00;
      qcost   <= 4'h0;
      q_up    <= 32'sh0;
      q_lo    <= 32'sh0;
      for (int i = 0; i < NAX; i++) begin
        upper[i] <= 32'sh0;
        lower[i] <= 32'sh0;
      end
    end else if (exec) begin
      qcost <= q_cost(pend_op, pa_mode[ax], enc_axis[ax]); // RULE18
      case (pend_op)
        `APJ_OP_POL_Q:    resp_ch <= invert[ax] ? `APJ_CH_INVERT : `APJ_CH_NORMAL; // RULE1
        `APJ_OP_POL_INV:  invert[ax] <= 1'b1; // RULE2 RULE21
        `APJ_OP_POL_NORM: invert[ax] <= 1'b0; // RULE3
        `APJ_OP_SLIP_OFF: slip_en[ax] <= 1'b0; // RULE7
        `APJ_OP_SLIP_ON:  slip_en[ax] <= 1'b1;
        `APJ_OP_TRAVEL: begin
          upper[ax] <= arg0; // RULE8
          lower[ax] <= arg1; // RULE8
        end
        `APJ_OP_TRAVEL_Q: begin
          q_up <= upper[ax]; // RULE13
          q_lo <= lower[ax]; // RULE13
        end
        default: ;
      endcase
    end
  end
  // jog launch, one pulse for all chosen axes
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      jog_start <= '0;
    end else begin
      jog_start <= (is_jog && ((jog_sel & jog_bad) == '0)) ? jog_sel : '0; // RULE16
    end
  end
  // sticky flags, a new event beats the clear
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      flag      <= '0;
      ovf       <= 1'b0;
      range_err <= 1'b0;
    end else begin
      flag      <= lim_hit | (flag & ~(wr_clr ? i_wr_data[NAX-1:0] : '0)); // RULE14
      ovf       <= (wr_cmd && !take_cmd) | (ovf & !(wr_clr && i_wr_data[4]));
      range_err <= (is_jog && ((jog_sel & jog_bad) != '0)) |
                   (range_err & !(wr_clr && i_wr_data[5])); // RULE15
    end
  end
  // field side outputs
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_kill       <= '0;
      o_limit      <= '0;
      o_limit_note <= 1'b0;
      o_sync_hold  <= 1'b0;
    end else begin
      o_kill       <= slip_en & i_slip_over; // RULE19
      o_limit      <= lim_hit; // RULE9
      o_limit_note <= |flag; // RULE14
      o_sync_hold  <= (ctl == apj_hold);
    end
  end
  // ------------------------------------------------------------
  // per-axis instances
  // ------------------------------------------------------------
  for (genvar g = 0; g < NAX; g++) begin : g_axis
    wire signed [15:0] cmd_v = $signed(i_servo_cmd[g*16 +: 16]);
    assign jog_bad[g] = (jtime[g] > `APJ_JOG_MAX_MS); // RULE15
    // output sense per axis
    always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
        o_servo_out[g*16 +: 16] <= 16'h0000;
      end else begin
        o_servo_out[g*16 +: 16] <= invert[g] ? 16'(-cmd_v) : cmd_v; // RULE2 RULE3
      end
    end
    apj_travel_limit #(.PW(32)) u_lim (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_pos      ($signed(i_axis_pos[g*32 +: 32])),
      .i_upper    (upper[g]),
      .i_lower    (lower[g]),
      .i_hard     (lim_s[g]),
      .o_hit      (lim_hit[g])
    );
    apj_jog_timer #(.TICKS_PER_MS(TICKS_PER_MS), .MS_W(18)) u_jog (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_start    (jog_start[g]),
      .i_ms       (jtime[g][17:0]),
      .i_at_rest  (i_at_rest[g]),
      .o_run      (o_jog_run[g]),
      .o_busy     (o_jog_busy[g])
    );
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  property p_pol_query;
    exec && (pend_op == `APJ_OP_POL_Q) |=>
      resp_ch == (invert[$past(ax)] ? `APJ_CH_INVERT : `APJ_CH_NORMAL);
  endproperty
  a_pol_query: assert property (p_pol_query) else $error("bad polarity answer"); // RULE1
  property p_pol_inv;
    exec && (pend_op == `APJ_OP_POL_INV) |=> invert[$past(ax)] ##1
      (invert[$past(ax, 2)] || $past(exec && (pend_op == `APJ_OP_POL_NORM)));
  endproperty
  a_pol_inv: assert property (p_pol_inv) else $error("invert not held"); // RULE2
  property p_pol_norm;
    exec && (pend_op == `APJ_OP_POL_NORM) |=> !invert[$past(ax)];
  endproperty
  a_pol_norm: assert property (p_pol_norm) else $error("normal not applied"); // RULE3
  property p_sync_hold;
    (ctl == apj_hold) && !release_w |=> (ctl == apj_hold) && !exec;
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("command ran during sync"); // RULE4
  property p_sync_go;
    (ctl == apj_hold) && release_w |=> ctl == apj_run;
  endproperty
  a_sync_go: assert property (p_sync_go) else $error("sync release missed"); // RULE6
  property p_slip_off;
    exec && (pend_op == `APJ_OP_SLIP_OFF) |=> !slip_en[$past(ax)] ##1 !o_kill[$past(ax, 2)];
  endproperty
  a_slip_off: assert property (p_slip_off) else $error("slip kill still on"); // RULE7
  property p_travel;
    exec && (pend_op == `APJ_OP_TRAVEL) |=>
      (upper[$past(ax)] == $past(arg0)) && (lower[$past(ax)] == $past(arg1));
  endproperty
  a_travel: assert property (p_travel) else $error("window not stored"); // RULE8
  property p_flag;
    lim_hit != '0 |=> ((flag & $past(lim_hit)) == $past(lim_hit)) ##1 o_limit_note;
  endproperty
  a_flag: assert property (p_flag) else $error("limit flag missed"); // RULE14
  property p_range;
    is_jog && ((jog_sel & jog_bad) != '0) |=> range_err && (jog_start == '0);
  endproperty
  a_range: assert property (p_range) else $error("jog range not refused"); // RULE15
  property p_kill;
    (slip_en & i_slip_over) != '0 |=> o_kill == $past(slip_en & i_slip_over);
  endproperty
  a_kill: assert property (p_kill) else $error("slip did not kill"); // RULE19
  c_sync: cover property (exec && (pend_op == `APJ_OP_SYNC) ##[1:100] ctl == apj_run);
  c_jog:  cover property ((jog_start != '0) ##1 (o_jog_busy != '0));
  c_lim:  cover property (lim_hit != '0 ##2 o_limit_note);
endmodule // apj_top

// file: rtl/apj_consts.svh
// constants for the axis polarity, limit, sync and jog block
`ifndef APJ_CONSTS_SVH
`define APJ_CONSTS_SVH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define APJ_OFF_CMD     8'h00
`define APJ_OFF_AXIS    8'h04
`define APJ_OFF_ARG0    8'h08
`define APJ_OFF_ARG1    8'h0C
`define APJ_OFF_STATUS  8'h10
`define APJ_OFF_RESP    8'h14
`define APJ_OFF_QUP     8'h18
`define APJ_OFF_QLO     8'h1C
`define APJ_OFF_FLAGCLR 8'h20
`define APJ_OFF_AXCFG   8'h24
`define APJ_OFF_JT_HI   4'h3
// ------------------------------------------------------------
// command opcodes, written into cmd[3:0]
// ------------------------------------------------------------
`define APJ_OP_POL_Q    4'h1
`define APJ_OP_POL_INV  4'h2
`define APJ_OP_POL_NORM 4'h3
`define APJ_OP_SYNC     4'h4
`define APJ_OP_SLIP_OFF 4'h5
`define APJ_OP_SLIP_ON  4'h6
`define APJ_OP_TRAVEL   4'h7
`define APJ_OP_TRAVEL_Q 4'h8
`define APJ_OP_JOG      4'h9
// ------------------------------------------------------------
// answers, limits, queue costs, timing
// ------------------------------------------------------------
`define APJ_NAX         4
`define APJ_CH_NORMAL   8'h6E
`define APJ_CH_INVERT   8'h69
`define APJ_JOG_MAX_MS  32'h00030D40
`define APJ_Q_JOG       4'h6
`define APJ_Q_SYNC      4'h2
`define APJ_Q_SLIP      4'h2
`define APJ_Q_TRAVEL    4'h3
`define APJ_Q_IMM       4'h0
`define APJ_CLK_NS      10
`define APJ_MS_NS       1000000
`define APJ_TICKS_PER_MS (`APJ_MS_NS / `APJ_CLK_NS)
`endif

// file: rtl/apj_pkg.sv
// types for the axis polarity, limit, sync and jog block
package apj_pkg;
  typedef enum logic [0:0] {
    apj_run  = 1'b0,
    apj_hold = 1'b1
  } apj_ctl_t;
  typedef enum logic [1:0] {
    apj_j_idle = 2'b00,
    apj_j_run  = 2'b01,
    apj_j_ramp = 2'b10
  } apj_jog_t;
endpackage

// file: rtl/apj_travel_limit.sv
// software travel window check for one axis
`include "apj_consts.svh"
module apj_travel_limit import apj_pkg::*; #(
  parameter int PW = 32
) (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst,
  input  wire logic signed [PW-1:0] i_pos,
  input  wire logic signed [PW-1:0] i_upper,
  input  wire logic signed [PW-1:0] i_lower,
  input  wire logic                 i_hard,
  output logic                      o_hit
);
  // ------------------------------------------------------------
  // window compare
  // ------------------------------------------------------------
  // both bounds zero switch the window off
  wire soft_en  = !((i_upper == '0) && (i_lower == '0)); // RULE12
  // absolute position register against both bounds
  wire soft_hit = soft_en && ((i_pos >= i_upper) || (i_pos <= i_lower)); // RULE9 RULE10

  // limit condition, soft or hard switch
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_hit <= 1'b0;
    end else begin
      o_hit <= soft_hit | i_hard; // RULE11
    end
  end
endmodule // apj_travel_limit

// file: rtl/apj_jog_timer.sv
// millisecond jog timer for one axis
`include "apj_consts.svh"
module apj_jog_timer import apj_pkg::*; #(
  parameter int TICKS_PER_MS = `APJ_TICKS_PER_MS,
  parameter int MS_W         = 18
) (
  input  wire logic            i_core_clk,
  input  wire logic            i_rst,
  input  wire logic            i_start,
  input  wire logic [MS_W-1:0] i_ms,
  input  wire logic            i_at_rest,
  output logic                 o_run,
  output logic                 o_busy
);
  localparam int TW = $clog2(TICKS_PER_MS + 1);
  apj_jog_t        st;
  logic [TW-1:0]   tick;
  logic [MS_W-1:0] ms_left;
  wire             tick_end = (tick == TW'(TICKS_PER_MS - 1));

  // ------------------------------------------------------------
  // run for the commanded time, then wait out the ramp down
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st      <= apj_j_idle;
      tick    <= '0;
      ms_left <= '0;
      o_run   <= 1'b0;
      o_busy  <= 1'b0;
    end else begin
      case (st)
        apj_j_idle: begin
          if (i_start) begin
            tick    <= '0;
            ms_left <= i_ms;
            o_busy  <= 1'b1; // RULE17
            o_run   <= (i_ms != '0);
            st      <= (i_ms != '0) ? apj_j_run : apj_j_ramp;
          end
        end
        apj_j_run: begin
          tick <= tick_end ? '0 : tick + 1'b1;
          if (tick_end) begin
            ms_left <= ms_left - 1'b1;
            if (ms_left == MS_W'(1)) begin
              o_run <= 1'b0; // RULE16
              st    <= apj_j_ramp;
            end
          end
        end
        apj_j_ramp: begin
          // busy covers the ramp until the axis reports rest
          if (i_at_rest) begin
            o_busy <= 1'b0; // RULE17
            st     <= apj_j_idle;
          end
        end
        default: begin
          st <= apj_j_idle;
        end
      endcase
    end
  end
endmodule // apj_jog_timer

// file: bench/apj_field_model.sv
// field side model: axis motion and ramp down to rest
module apj_field_model #(
  parameter int RAMP = 5
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic [3:0] i_jog_run,
  output logic      [3:0] o_at_rest
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt [4];
  // ----------------------------------------
  // motion per axis
  // ----------------------------------------
  // moving while jog runs, then a decel ramp before rest
  always @(posedge i_core_clk) begin
    for (int n = 0; n < 4; n++) begin
      if (i_rst) begin
        cnt[n] = 0;
        o_at_rest[n] <= 1'b1;
      end else if (i_jog_run[n]) begin
        cnt[n] = RAMP;
        o_at_rest[n] <= 1'b0;
      end else if (cnt[n] > 0) begin
        cnt[n] = cnt[n] - 1;
        o_at_rest[n] <= (cnt[n] == 0);
      end
    end
  end
endmodule // apj_field_model

// file: bench/tb_axis_polarity_limit_sync_jog.sv
// self-checking bench for the axis polarity, limit, sync and jog block
`include "apj_consts.svh"
module tb_axis_polarity_limit_sync_jog import apj_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TPM = 4;
  localparam int RAMP = 5;
  logic i_core_clk, i_rst, i_wr, i_rd, o_limit_note, o_sync_hold;
  logic [7:0] i_addr, i_gpio;
  logic [31:0] i_wr_data, o_rd_data;
  logic [3:0] i_limit_sw, i_slip_over, i_at_rest, o_kill, o_limit, o_jog_run, o_jog_busy;
  logic [127:0] i_axis_pos;
  logic [63:0] i_servo_cmd, o_servo_out;
  int errors, num_checks, seed;
  int inv [4];
  int runc [4];
  int rampc [4];
  time t0 [4];
  int pos_tab [5] = '{99, 100, -100, -99, 0};
  apj_top #(.TICKS_PER_MS(TPM)) uut (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
    .o_rd_data(o_rd_data), .i_gpio(i_gpio), .i_limit_sw(i_limit_sw),
    .i_axis_pos(i_axis_pos), .i_servo_cmd(i_servo_cmd), .i_slip_over(i_slip_over),
    .i_at_rest(i_at_rest), .o_servo_out(o_servo_out), .o_kill(o_kill),
    .o_limit(o_limit), .o_limit_note(o_limit_note), .o_jog_run(o_jog_run),
    .o_jog_busy(o_jog_busy), .o_sync_hold(o_sync_hold));
  apj_field_model #(.RAMP(RAMP)) fld (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_jog_run(o_jog_run), .o_at_rest(i_at_rest));
  // clock, 10 ns period
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  // jog monitor: run cycles, ramp cycles, first run edge
  always @(posedge i_core_clk) begin
    for (int n = 0; n < 4; n++) begin
      if (o_jog_run[n] === 1'b1) runc[n]++;
      if (o_jog_busy[n] === 1'b1 && o_jog_run[n] === 1'b0) rampc[n]++;
      if (o_jog_run[n] === 1'b1 && t0[n] == 0) t0[n] = $time;
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wr_data <= d;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rd_data & m, e);
  endtask
  task automatic cmd(input int ax, input logic [31:0] c);
    wr(`APJ_OFF_AXIS, ax);
    wr(`APJ_OFF_CMD, c);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  // random demand in, compare each axis with its sense
  task automatic servo_chk();
    logic [15:0] dmd;
    @(posedge i_core_clk);
    i_servo_cmd <= {$random(seed), $random(seed)};
    tick(4);
    for (int n = 0; n < 4; n++) begin
      dmd = i_servo_cmd[16*n+:16];
      chk(o_servo_out[16*n+:16], inv[n] ? 16'(-dmd) : dmd);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // watchdog
  initial begin
    #100us;
    errors++;
    summarize();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'hED66;
    {i_rst, i_wr, i_rd, i_addr, i_wr_data} = {1'b1, 42'h0};
    {i_gpio, i_limit_sw, i_slip_over, i_axis_pos, i_servo_cmd} = '0;
    repeat (3) @(posedge i_core_clk);
    i_rst <= 1'b0;
    // polarity: default, invert, per axis, restore
    cmd(0, `APJ_OP_POL_Q);
    rchk(`APJ_OFF_RESP, 32'hFF, `APJ_CH_NORMAL);
    rchk(`APJ_OFF_STATUS, 32'h000F0F00, 32'h0);
    cmd(1, `APJ_OP_POL_INV);
    inv[1] = 1;
    cmd(1, `APJ_OP_POL_Q);
    rchk(`APJ_OFF_RESP, 32'hFF, `APJ_CH_INVERT);
    cmd(0, `APJ_OP_POL_Q);
    rchk(`APJ_OFF_RESP, 32'hFF, `APJ_CH_NORMAL);
    servo_chk();
    cmd(1, `APJ_OP_POL_NORM);
    inv[1] = 0;
    servo_chk();
    // slip guard on axis 2 only, then off
    cmd(2, `APJ_OP_SLIP_ON);
    i_slip_over <= 4'hF;
    tick(3);
    chk(o_kill, 4'h4);
    cmd(2, `APJ_OP_SLIP_OFF);
    tick(3);
    chk(o_kill, 4'h0);
    i_slip_over <= 4'h0;
    // travel window on axis 0
    wr(`APJ_OFF_ARG0, 32'd100);
    wr(`APJ_OFF_ARG1, -32'sd100);
    cmd(0, `APJ_OP_TRAVEL);
    cmd(0, `APJ_OP_TRAVEL_Q);
    rchk(`APJ_OFF_QUP, 32'hFFFFFFFF, 32'd100);
    rchk(`APJ_OFF_QLO, 32'hFFFFFFFF, -32'sd100);
    cmd(1, `APJ_OP_TRAVEL_Q);
    rchk(`APJ_OFF_QUP, 32'hFFFFFFFF, 32'd0);
    foreach (pos_tab[k]) begin
      i_axis_pos <= {96'h0, 32'(pos_tab[k])};
      tick(6);
      chk(o_limit[0], pos_tab[k] >= 100 || pos_tab[k] <= -100);
    end
    chk(o_limit_note, 1'b1);
    rchk(`APJ_OFF_STATUS, 32'hF0, 32'h10);
    wr(`APJ_OFF_FLAGCLR, 32'hF);
    rchk(`APJ_OFF_STATUS, 32'hF0, 32'h0);
    i_limit_sw <= 4'h1;
    tick(8);
    chk(o_limit, 4'h1);
    i_limit_sw <= 4'h0;
    wr(`APJ_OFF_ARG0, 32'd0);
    wr(`APJ_OFF_ARG1, 32'd0);
    cmd(0, `APJ_OP_TRAVEL);
    i_axis_pos <= {96'h0, 32'd500};
    tick(8);
    chk(o_limit, 4'h0);
    // sync wait on line 3 holds a pending command
    wr(`APJ_OFF_ARG0, 32'd3);
    cmd(0, `APJ_OP_SYNC);
    wr(`APJ_OFF_CMD, `APJ_OP_POL_INV);
    wr(`APJ_OFF_CMD, `APJ_OP_POL_NORM);
    rchk(`APJ_OFF_STATUS, 32'h4, 32'h4);
    i_gpio <= 8'hF7;
    tick(20);
    chk(o_sync_hold, 1'b1);
    rchk(`APJ_OFF_STATUS, 32'h10000, 32'h0);
    i_gpio <= 8'h08;
    tick(6);
    chk(o_sync_hold, 1'b0);
    rchk(`APJ_OFF_STATUS, 32'h10000, 32'h10000);
    cmd(0, `APJ_OP_POL_NORM);
    // two axes jog together, each for its own time
    wr(`APJ_OFF_AXCFG, 32'h0);
    wr(8'h30, 32'd2);
    wr(8'h38, 32'd3);
    foreach (runc[n]) {runc[n], rampc[n], t0[n]} = '0;
    cmd(0, 32'h59);
    rchk(`APJ_OFF_RESP, 32'hF00, 32'h600);
    for (int w = 0; w < 200 && o_jog_busy !== 4'h0; w++) tick(1);
    chk(runc[0], 2 * TPM);
    chk(runc[2], 3 * TPM);
    chk(t0[0] == t0[2], 1'b1);
    chk(rampc[0] >= RAMP, 1'b1);
    chk(o_jog_busy, 4'h0);
    // out of range refused, top of range accepted, costs with extras
    wr(`APJ_OFF_AXCFG, 32'h11);
    wr(8'h30, 32'd200001);
    cmd(0, 32'h9);
    tick(4);
    chk(o_jog_busy, 4'h0);
    rchk(`APJ_OFF_STATUS, 32'h8, 32'h8);
    wr(`APJ_OFF_FLAGCLR, 32'h20);
    wr(8'h30, 32'd200000);
    cmd(0, 32'h9);
    tick(4);
    chk(o_jog_busy, 4'h1);
    rchk(`APJ_OFF_STATUS, 32'h8, 32'h0);
    rchk(`APJ_OFF_RESP, 32'hF00, 32'h800);
    summarize();
  end
endmodule // tb_axis_polarity_limit_sync_jog
